// ---- bench/fast_pulse_counter_assertions.sv ----
// Port-level checks for the fast pulse counter.
`timescale 1ns/1ps
module fast_pulse_counter_checker
    import fast_counter_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [CHANNELS-1:0] fast_counter_input_in,
    input wire logic [2*CHANNELS-1:0] mode_in,
    input wire logic [CHANNELS-1:0] falling_edge_in,
    input wire logic [ACC_WIDTH-1:0] modulus0_in,
    input wire logic [ACC_WIDTH-1:0] modulus1_in,
    input wire logic [CHANNELS-1:0] counter_clear_bits_in,
    input wire logic [ACC_WIDTH-1:0] measurement_result_word0_out,
    input wire logic [ACC_WIDTH-1:0] measurement_result_word1_out,
    input wire logic [ACC_WIDTH-1:0] measurement_result_word2_out,
    input wire logic [ACC_WIDTH-1:0] measurement_result_word3_out
);
    // ****************
    // Checks.
    // ****************
    // A quiet channel totalizes with no clear pending from a bit or an input.
    wire logic [31:0] w0 = measurement_result_word0_out;
    wire logic [31:0] w1 = measurement_result_word1_out;
    wire logic [31:0] w2 = measurement_result_word2_out;
    wire logic [31:0] w3 = measurement_result_word3_out;
    wire logic [3:0] p = fast_counter_input_in;
    wire logic [7:0] m = mode_in;
    wire logic [3:0] f = falling_edge_in;
    wire logic q0 = m[1:0] == 2'h2 && !counter_clear_bits_in[0] && m[5:4] != 2'h3;
    wire logic q1 = m[3:2] == 2'h2 && !counter_clear_bits_in[1] && m[7:6] != 2'h3;
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // The compare is at or above modulus minus one, so a lowered modulus wraps at once.
    function automatic logic [31:0] nx(logic [31:0] v, logic [31:0] md);
        return (md != 32'h0 && v >= md - 32'h1) ? 32'h0 : v + 32'h1;
    endfunction
    sequence s_r0; $rose(p[0]) && q0 && !f[0] ##1 q0; endsequence
    sequence s_f1; $fell(p[1]) && q1 && f[1] ##1 q1; endsequence
    property p_rst; disable iff (1'b0) srst_in |=> (w0 | w1 | w2 | w3) == 32'h0; endproperty
    property p_r0; s_r0 |=> w0 == nx($past(w0, 2), modulus0_in); endproperty
    property p_f1; s_f1 |=> w1 == nx($past(w1, 2), modulus1_in); endproperty
    property p_wrong; $fell(p[0]) && q0 && !f[0] ##1 q0 |=> $stable(w0); endproperty
    property p_idle; (q0 && $stable(p[0]))[*3] |=> $stable(w0); endproperty
    property p_clr; (m[1:0] == 2'h2 && counter_clear_bits_in[0])[*2] |=> w0 == 32'h0; endproperty
    property p_hw; $rose(p[2]) && m[5:4] == 2'h3 && !f[2] && m[1:0] == 2'h2 |-> ##3 w0 == 32'h0; endproperty
    property p_off; (m[5:4] == 2'h0 || m[5:4] == 2'h3)[*3] |-> w2 == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("Word after reset");
    a_r0: assert property (p_r0) else $error("Rising count");
    a_f1: assert property (p_f1) else $error("Falling count");
    a_wrong: assert property (p_wrong) else $error("Wrong edge counted");
    a_idle: assert property (p_idle) else $error("Count without edge");
    a_clr: assert property (p_clr) else $error("Clear bit");
    a_hw: assert property (p_hw) else $error("Input clear");
    a_off: assert property (p_off) else $error("Idle channel word");
endmodule
bind fast_pulse_counter fast_pulse_counter_checker chk_u (.*);

// ---- bench/pulse_source.sv ----
// Behavioural pulse source standing in for a sensor on the counter inputs.
`timescale 1ns/1ps
module pulse_source #(parameter int HALF = 2600) (
    input wire logic clock_in,
    input wire logic run_in,
    output logic pulse_out
);
    int cnt = 0;
    initial pulse_out = 1'b0;
    // Each level lasts HALF cycles, over 100 us; a stop waits for the low level so no runt pulse is left.
    always @(posedge clock_in) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1 && (run_in || pulse_out)) begin
            pulse_out <= !pulse_out;
        end
    end
endmodule

// ---- bench/tb_fast_pulse_counter.sv ----
// Self-checking bench for the fast pulse counter totalize and clear paths.
`timescale 1ns/1ps
module tb_fast_pulse_counter
    import fast_counter_pkg::*;
;
    logic clock_in;
    logic srst_in = 1'b1;
    logic run = 1'b0;
    logic src;
    logic pin2 = 1'b0;
    logic [7:0] mode = 8'h00;
    logic [3:0] fall = 4'h0;
    logic [31:0] mod0 = 32'h0;
    logic [3:0] clr = 4'h0;
    logic [31:0] w0, w1, w2, w3;
    int err_count = 0;
    int checked = 0;
    // One source feeds channels 0, 1 and the frequency channel 3; the bench drives channel 2.
    // The shortest window outlasts the whole run, so channel 3 can only be shown not to report early.
    pulse_source #(.HALF(2600)) src_u (.clock_in(clock_in), .run_in(run), .pulse_out(src));
    fast_pulse_counter dut_u (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .fast_counter_input_in({src, pin2, src, src}),
        .mode_in(mode),
        .window_in(8'h00),
        .falling_edge_in(fall),
        .modulus0_in(mod0),
        .modulus1_in(32'h0),
        .modulus2_in(32'h0),
        .modulus3_in(32'h0),
        .counter_clear_bits_in(clr),
        .measurement_result_word0_out(w0),
        .measurement_result_word1_out(w1),
        .measurement_result_word2_out(w2),
        .measurement_result_word3_out(w3)
    );
    // ****************
    // Tasks.
    // ****************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Outputs are read at the falling edge, once the rising edge updates have landed.
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        @(negedge clock_in);
    endtask
    task automatic pulses(input int n);
        @(posedge clock_in);
        run <= 1'b1;
        repeat (n) @(negedge src);
        @(posedge clock_in);
        run <= 1'b0;
        settle(4);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************
    // Clock, watchdog and tests.
    // ****************
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // The tests need about 60000 cycles; the limit allows 80000.
    initial begin
        #3_200_000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        @(negedge clock_in);
        chk(w0 | w1 | w2 | w3, 32'h0);
        $display("Test reset done");
        @(posedge clock_in);
        mode <= 8'h4A;
        fall <= 4'h2;
        mod0 <= 32'h3;
        pulses(4);
        chk(w0, 32'h1);
        chk(w1, 32'h4);
        chk(w3, 32'h0);
        pulses(2);
        chk(w0, 32'h0);
        chk(w1, 32'h6);
        $display("Test totalize done");
        @(posedge clock_in);
        clr <= 4'h1;
        pulses(2);
        chk(w0, 32'h0);
        chk(w1, 32'h8);
        @(posedge clock_in);
        clr <= 4'h0;
        pulses(1);
        chk(w0, 32'h1);
        chk(w3, 32'h0);
        $display("Test clear bits done");
        // Clears are checked just inside the allowed latency, not after it.
        @(posedge clock_in);
        mode <= 8'h3A;
        pin2 <= 1'b1;
        settle(CLEAR_LATENCY_CYCLES - 2);
        chk(w0, 32'h0);
        chk(w2, 32'h0);
        pulses(1);
        chk(w0, 32'h1);
        @(posedge clock_in);
        fall <= 4'h6;
        pin2 <= 1'b0;
        settle(CLEAR_LATENCY_CYCLES - 2);
        chk(w0, 32'h0);
        $display("Test input clear done");
        // A reset in mid-run must drop every word, and counting must restart from zero after it.
        @(posedge clock_in);
        srst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        @(negedge clock_in);
        chk(w0 | w1 | w2 | w3, 32'h0);
        pulses(1);
        chk(w0, 32'h1);
        chk(w1, 32'h1);
        $display("Test mid-run reset done");
        end_of_test();
    end
endmodule

// ---- hw/fast_counter_channel.sv ----
// One fast counter channel: edge detection, totalizer and frequency meter.
`timescale 1ns/1ps
module fast_counter_channel
    import fast_counter_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic tick_in,
    input wire logic pin_in,
    input wire logic [1:0] mode_in,
    input wire logic [1:0] window_in,
    input wire logic falling_in,
    input wire logic [ACC_WIDTH-1:0] modulus_in,
    input wire logic clear_in,
    input wire logic hw_clear_in,
    output logic edge_out,
    output logic [ACC_WIDTH-1:0] result_out
);

    // ****************************************
    // Edge detection and accumulation.
    // ****************************************
    logic pin_last;
    logic [ACC_WIDTH-1:0] acc;
    logic [ACC_WIDTH-1:0] cycles;
    logic [WINDOW_WIDTH-1:0] win_cnt;
    logic [ACC_WIDTH-1:0] next_acc;
    logic [ACC_WIDTH-1:0] next_cycles;
    logic [WINDOW_WIDTH-1:0] next_win_cnt;
    logic [WINDOW_WIDTH-1:0] win_len;
    logic [6:0] win_scale;
    logic counted_edge;
    logic rise;
    logic [38:0] scaled;

    // Edge polarity is always taken on the raw pin level, so negative logic needs the opposite edge.
    assign rise = pin_in && !pin_last;
    assign counted_edge = falling_in ? (!pin_in && pin_last) : rise;
    assign edge_out = counted_edge;

    // Longer windows gather more cycles, so resolution improves but the update comes later.
    always_comb begin
        case (window_e'(window_in))
            WINDOW_10MS: begin
                win_len = WIN0_US;
                win_scale = WIN0_SCALE;
            end
            WINDOW_100MS: begin
                win_len = WIN1_US;
                win_scale = WIN1_SCALE;
            end
            WINDOW_500MS: begin
                win_len = WIN2_US;
                win_scale = WIN2_SCALE;
            end
            default: begin
                win_len = WIN3_US;
                win_scale = WIN3_SCALE;
            end
        endcase
    end

    // Next values for the accumulator and the frequency gate.
    always_comb begin
        next_acc = acc;
        next_cycles = cycles;
        next_win_cnt = win_cnt;
        scaled = cycles * win_scale;
        case (mode_e'(mode_in))
            MODE_TOTALIZE: begin
                next_cycles = ACC_ZERO;
                next_win_cnt = '0;
                if (clear_in || hw_clear_in) begin
                    next_acc = ACC_ZERO;
                end else if (counted_edge) begin
                    if (modulus_in != ACC_ZERO && acc >= modulus_in - ACC_ONE) begin
                        next_acc = ACC_ZERO;
                    end else begin
                        next_acc = acc + ACC_ONE;
                    end
                end
            end
            MODE_FREQUENCY: begin
                if (rise) begin
                    next_cycles = cycles + ACC_ONE;
                end
                if (tick_in) begin
                    if (win_cnt >= win_len - 20'h0_0001) begin
                        next_win_cnt = '0;
                        next_acc = scaled[ACC_WIDTH-1:0];
                        next_cycles = rise ? ACC_ONE : ACC_ZERO;
                    end else begin
                        next_win_cnt = win_cnt + 20'h0_0001;
                    end
                end
            end
            default: begin
                next_acc = ACC_ZERO;
                next_cycles = ACC_ZERO;
                next_win_cnt = '0;
            end
        endcase
    end

    // Register stage.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pin_last <= 1'b0;
            acc <= ACC_ZERO;
            cycles <= ACC_ZERO;
            win_cnt <= '0;
        end else begin
            pin_last <= pin_in;
            acc <= next_acc;
            cycles <= next_cycles;
            win_cnt <= next_win_cnt;
        end
    end

    assign result_out = acc;

endmodule

// ---- hw/fast_counter_pkg.sv ----
// Shared constants and types for the four-channel fast pulse counter.
package fast_counter_pkg;

    // ****************************************
    // Geometry and timing.
    // ****************************************
    localparam int unsigned CHANNELS = 4;
    localparam int unsigned ACC_WIDTH = 32;
    localparam int unsigned CLOCK_HZ = 25_000_000;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYCLES = (CLOCK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned TICK_WIDTH = 5;
    localparam int unsigned MIN_EDGE_US = 100;
    localparam int unsigned CLEAR_LATENCY_US = 100;
    localparam int unsigned CLEAR_LATENCY_CYCLES = (CLOCK_HZ / 1_000_000) * CLEAR_LATENCY_US;

    // Frequency sample windows in microseconds and the factor that scales a count to hertz.
    localparam int unsigned WINDOW_WIDTH = 20;
    localparam logic [19:0] WIN0_US = 20'h0_2710;
    localparam logic [19:0] WIN1_US = 20'h1_86A0;
    localparam logic [19:0] WIN2_US = 20'h7_A120;
    localparam logic [19:0] WIN3_US = 20'hF_4240;
    localparam logic [6:0] WIN0_SCALE = 7'h64;
    localparam logic [6:0] WIN1_SCALE = 7'h0A;
    localparam logic [6:0] WIN2_SCALE = 7'h02;
    localparam logic [6:0] WIN3_SCALE = 7'h01;

    localparam logic [ACC_WIDTH-1:0] ACC_ZERO = 32'h0000_0000;
    localparam logic [ACC_WIDTH-1:0] ACC_ONE = 32'h0000_0001;

    // ****************************************
    // Mode and window encodings.
    // ****************************************
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_FREQUENCY,
        MODE_TOTALIZE,
        MODE_CLEAR_SOURCE
    } mode_e;

    typedef enum logic [1:0] {
        WINDOW_10MS,
        WINDOW_100MS,
        WINDOW_500MS,
        WINDOW_1S
    } window_e;

endpackage

// ---- hw/fast_pulse_counter.sv ----
// Top level of the four-input fast pulse counter with frequency and totalize modes.
`timescale 1ns/1ps

// Notes on behaviour
// - Four fast counter inputs each take their own mode, and some modes use a second input.
// - Each channel's measurement result word is presented as an output for the controller program.
// - All time measurement runs from a one microsecond tick.
// - Configured edge polarity always refers to the raw pin level.
// - Frequency mode writes cycles per second to the accumulator.
// - Frequency mode has four selectable sample windows that set the gathering interval.
// - Shorter windows update sooner but with coarser resolution and a higher lowest frequency.
// - Totalize mode adds one on each edge of the configured direction.
// - With a nonzero modulus the totalizer goes from modulus minus one to zero on the next edge.
// - A zero modulus lets the totalizer run through its full 32-bit range.
// - While its clear bit is high a totalizer is held at zero.
// - Inputs three and four may act as edge-triggered clears for totalizers one and two.
// - A hardware clear edge reaches its totalizer within 100 us.
module fast_pulse_counter
    import fast_counter_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [CHANNELS-1:0] fast_counter_input_in,
    input wire logic [2*CHANNELS-1:0] mode_in,
    input wire logic [2*CHANNELS-1:0] window_in,
    input wire logic [CHANNELS-1:0] falling_edge_in,
    input wire logic [ACC_WIDTH-1:0] modulus0_in,
    input wire logic [ACC_WIDTH-1:0] modulus1_in,
    input wire logic [ACC_WIDTH-1:0] modulus2_in,
    input wire logic [ACC_WIDTH-1:0] modulus3_in,
    input wire logic [CHANNELS-1:0] counter_clear_bits_in,
    output logic [ACC_WIDTH-1:0] measurement_result_word0_out,
    output logic [ACC_WIDTH-1:0] measurement_result_word1_out,
    output logic [ACC_WIDTH-1:0] measurement_result_word2_out,
    output logic [ACC_WIDTH-1:0] measurement_result_word3_out
);

    // ****************************************
    // Microsecond timebase.
    // ****************************************
    logic [TICK_WIDTH-1:0] tick_cnt;
    logic [TICK_WIDTH-1:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    // The tick is a single-cycle strobe once every microsecond.
    always_comb begin
        if (tick_cnt == TICK_WIDTH'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
            next_tick = 1'b1;
        end else begin
            next_tick_cnt = tick_cnt + TICK_WIDTH'(1);
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    // ****************************************
    // Channels.
    // ****************************************
    logic [ACC_WIDTH-1:0] modulus [CHANNELS];
    logic [ACC_WIDTH-1:0] result [CHANNELS];
    logic [CHANNELS-1:0] edges;
    logic [CHANNELS-1:0] hw_clear;

    assign modulus[0] = modulus0_in;
    assign modulus[1] = modulus1_in;
    assign modulus[2] = modulus2_in;
    assign modulus[3] = modulus3_in;

    // Inputs three and four clear totalizers one and two on their configured edge; the clear lands
    // one cycle after the edge, far inside the allowed latency.
    always_comb begin
        hw_clear = '0;
        hw_clear[0] = edges[2] && (mode_e'(mode_in[5:4]) == MODE_CLEAR_SOURCE);
        hw_clear[1] = edges[3] && (mode_e'(mode_in[7:6]) == MODE_CLEAR_SOURCE);
    end

    // Each input has its own channel; a clear-source channel keeps its result at zero.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_channel
            fast_counter_channel u_channel (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .tick_in(tick),
                .pin_in(fast_counter_input_in[g]),
                .mode_in(mode_in[2*g+1:2*g]),
                .window_in(window_in[2*g+1:2*g]),
                .falling_in(falling_edge_in[g]),
                .modulus_in(modulus[g]),
                .clear_in(counter_clear_bits_in[g]),
                .hw_clear_in(hw_clear[g]),
                .edge_out(edges[g]),
                .result_out(result[g])
            );
        end
    endgenerate

    // ****************************************
    // Result words.
    // ****************************************

    // Results are re-registered so every output comes straight from a flip-flop.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            measurement_result_word0_out <= ACC_ZERO;
            measurement_result_word1_out <= ACC_ZERO;
            measurement_result_word2_out <= ACC_ZERO;
            measurement_result_word3_out <= ACC_ZERO;
        end else begin
            measurement_result_word0_out <= result[0];
            measurement_result_word1_out <= result[1];
            measurement_result_word2_out <= result[2];
            measurement_result_word3_out <= result[3];
        end
    end

endmodule
